// >>> hdl/ddh_config_port.sv
// Host configuration port: parallel and serial access to a byte map,
// buffered writes, update-event copy, master reset.
// Assumes pins are asynchronous; the serial clock is far slower than clk_i.
`timescale 1ns/1ps
`default_nettype none
module ddh_config_port
  import ddh_pkg::*;
#(
  parameter int REF_TIMEOUT = 64
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic mode_sel_i,
  input wire logic master_reset_i,
  input wire logic reference_clock_in_i,
  input wire logic update_strobe_i,
  output logic update_strobe_o,
  output logic update_strobe_oe_b_o,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_b_o,
  output logic serial_out_line_o,
  output logic serial_out_line_oe_b_o,
  output logic sdio_o,
  output logic sdio_oe_b_o,
  output ddh_ctrl_s ctrl_o,
  output logic mult_valid_o,
  output logic ref_present_o
);
  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  ddh_pins_s pins, s1, s2, s3, pf, pf_q;
  assign pins = '{master_reset_i, reference_clock_in_i, update_strobe_i, mode_sel_i,
                  write_strobe_n_i, read_strobe_n_i, addr_i, data_i};

  // A bit changes only once the second and third stages agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= PINS_IDLE;
      s2 <= PINS_IDLE;
      s3 <= PINS_IDLE;
      pf <= PINS_IDLE;
      pf_q <= PINS_IDLE;
    end else if (ce_i) begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      pf <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pf);
      pf_q <= pf;
    end
  end

  logic [7:0] buf_mem [0:REG_BYTES-1];
  logic [7:0] act_mem [0:REG_BYTES-1];

  // ------------------------------------------------------------------
  // Master reset and reference clock presence
  // ------------------------------------------------------------------
  logic [3:0] mrst_cnt;
  logic init_now;
  assign init_now = pf.mrst && (mrst_cnt == MRST_MIN_CYC);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mrst_cnt <= 4'h0;
    end else if (ce_i) begin
      if (!pf.mrst) begin
        mrst_cnt <= 4'h0;
      end else if (mrst_cnt != MRST_MIN_CYC) begin
        mrst_cnt <= mrst_cnt + 4'h1;
      end
    end
  end

  // Presence is a watchdog on sampled edges, so very slow references look absent
  logic [7:0] ref_cnt;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_cnt <= 8'h00;
    end else if (ce_i) begin
      if (pf.reference_clock_in != pf_q.reference_clock_in) begin
        ref_cnt <= 8'(REF_TIMEOUT);
      end else if (ref_cnt != 8'h00) begin
        ref_cnt <= ref_cnt - 8'h01;
      end
    end
  end
  assign ref_present_o = (ref_cnt != 8'h00);

  // ------------------------------------------------------------------
  // Update event generation
  // ------------------------------------------------------------------
  logic int_sel, int_tick, ext_tick, upd_event;
  logic [31:0] upd_n, upd_cnt;
  logic [3:0] pulse_cnt;
  assign int_sel = act_mem[OP_MODE_OFS][INT_UPD_BIT];
  assign upd_n = {act_mem[6'h16], act_mem[6'h17], act_mem[6'h18], act_mem[6'h19]};
  assign int_tick = int_sel && ref_present_o && (upd_cnt >= upd_n);
  assign ext_tick = !int_sel && pf.ud && !pf_q.ud;
  assign upd_event = (int_tick || ext_tick) && ref_present_o && !init_now;

  // Period is N+1 system cycles; counting stops with the reference
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upd_cnt <= 32'h0;
    end else if (ce_i) begin
      if (!int_sel || init_now || int_tick) begin
        upd_cnt <= 32'h0;
      end else if (ref_present_o) begin
        upd_cnt <= upd_cnt + 32'h1;
      end
    end
  end

  // Short periods retrigger the stretch and keep the pin high
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_cnt <= 4'h0;
    end else if (ce_i) begin
      // A tick that switches to external updates still finishes its pulse
      if (init_now) begin
        pulse_cnt <= 4'h0;
      end else if (int_tick) begin
        pulse_cnt <= UD_PULSE_CYC;
      end else if (pulse_cnt != 4'h0) begin
        pulse_cnt <= pulse_cnt - 4'h1;
      end
    end
  end
  assign update_strobe_o = (pulse_cnt != 4'h0);
  assign update_strobe_oe_b_o = !int_sel && (pulse_cnt == 4'h0);

  // ------------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------------
  ddh_ser_e ser_state;
  ddh_span_s span, next_span;
  logic [2:0] bit_cnt, byte_cnt, pos, byte_ofs;
  logic [7:0] shreg, next_shreg;
  logic rd_dir, out_bit, lsb, split, cs_n, ser_active, rise, fall, ser_wr, ser_drive;
  logic [5:0] ser_addr;
  assign lsb = act_mem[OUT_PORT_OFS][LSB_FIRST_BIT];
  assign split = act_mem[OUT_PORT_OFS][SPLIT_OUT_BIT];
  assign cs_n = pf.rd_n;
  assign ser_active = !pf.mode && !cs_n;
  assign rise = ser_active && !pf_q.wr_n && pf.wr_n;
  assign fall = ser_active && pf_q.wr_n && !pf.wr_n;
  assign pos = lsb ? bit_cnt : 3'h7 - bit_cnt;
  assign byte_ofs = lsb ? span.len - 3'h1 - byte_cnt : byte_cnt;
  assign ser_addr = span.base + {3'h0, byte_ofs};

  always_comb begin
    next_shreg = shreg;
    next_shreg[pos] = pf.addr[0];
  end
  assign next_span = ddh_span(next_shreg[3:0]);
  assign ser_wr = rise && (ser_state == SER_DATA) && !rd_dir && (bit_cnt == 3'h7);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ser_state <= SER_INSTR;
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      shreg <= 8'h00;
      rd_dir <= 1'b0;
      span <= '0;
    end else if (ce_i) begin
      if (init_now || pf.addr[2] || pf.mode) begin
        ser_state <= SER_INSTR;
        bit_cnt <= 3'h0;
        byte_cnt <= 3'h0;
      end else if (rise) begin
        // Pauses under chip select high, since rise needs it low
        shreg <= next_shreg;
        bit_cnt <= bit_cnt + 3'h1;
        case (ser_state)
          SER_INSTR: begin
            if (bit_cnt == 3'h7) begin
              rd_dir <= next_shreg[INSTR_RW_BIT];
              span <= next_span;
              byte_cnt <= 3'h0;
              ser_state <= (next_span.len == 3'h0) ? SER_INSTR : SER_DATA;
            end
          end
          SER_DATA: begin
            if (bit_cnt == 3'h7) begin
              byte_cnt <= byte_cnt + 3'h1;
              if (byte_cnt == span.len - 3'h1) begin
                ser_state <= SER_INSTR;
              end
            end
          end
          default: begin
            ser_state <= SER_INSTR;
          end
        endcase
      end
    end
  end

  // Read bits change on falling edges from the active copy
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_bit <= 1'b0;
    end else if (ce_i) begin
      if (rise && ser_state == SER_INSTR && bit_cnt == 3'h7) begin
        out_bit <= 1'b0;
      end else if (fall && ser_state == SER_DATA && rd_dir) begin
        out_bit <= act_mem[ser_addr][pos];
      end
    end
  end

  assign ser_drive = ser_active && (ser_state == SER_DATA) && rd_dir;
  assign sdio_o = out_bit;
  assign serial_out_line_o = out_bit;
  assign sdio_oe_b_o = !(ser_drive && !split);
  assign serial_out_line_oe_b_o = !(ser_drive && split);

  // ------------------------------------------------------------------
  // Parallel port and buffer memory
  // ------------------------------------------------------------------
  logic par_wr;
  assign par_wr = pf.mode && !pf_q.wr_n && pf.wr_n;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < REG_BYTES; i++) begin
        buf_mem[i] <= ddh_default(6'(i));
      end
    end else if (ce_i) begin
      if (init_now) begin
        for (int i = 0; i < REG_BYTES; i++) begin
          buf_mem[i] <= ddh_default(6'(i));
        end
      end else if (par_wr && ddh_writable(pf.addr)) begin
        buf_mem[pf.addr] <= pf.data;
      end else if (ser_wr && ddh_writable(ser_addr)) begin
        buf_mem[ser_addr] <= next_shreg;
      end
    end
  end

  // Readback shows the active copy, one sample behind the filtered pins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= 8'h00;
    end else if (ce_i) begin
      data_o <= (pf.addr <= LAST_OFS) ? act_mem[pf.addr] : 8'h00;
    end
  end
  assign data_oe_b_o = !(pf.mode && !pf.rd_n);

  // ------------------------------------------------------------------
  // Active registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < REG_BYTES; i++) begin
        act_mem[i] <= ddh_default(6'(i));
      end
    end else if (ce_i) begin
      if (init_now) begin
        for (int i = 0; i < REG_BYTES; i++) begin
          act_mem[i] <= ddh_default(6'(i));
        end
      end else if (upd_event) begin
        for (int i = 0; i < REG_BYTES; i++) begin
          act_mem[i] <= buf_mem[i];
        end
      end else if (act_mem[OP_MODE_OFS][ACC_PULSE_BIT]) begin
        // One-shot clear leaves the buffer untouched
        act_mem[OP_MODE_OFS][ACC_PULSE_BIT] <= 1'b0;
      end
    end
  end

  assign ctrl_o.phase_one = {act_mem[6'h00][5:0], act_mem[6'h01]};
  assign ctrl_o.phase_two = {act_mem[6'h02][5:0], act_mem[6'h03]};
  assign ctrl_o.tune_one = {act_mem[6'h04], act_mem[6'h05], act_mem[6'h06],
                            act_mem[6'h07], act_mem[6'h08], act_mem[6'h09]};
  assign ctrl_o.tune_two = {act_mem[6'h0A], act_mem[6'h0B], act_mem[6'h0C],
                            act_mem[6'h0D], act_mem[6'h0E], act_mem[6'h0F]};
  assign ctrl_o.sweep_step = {act_mem[6'h10], act_mem[6'h11], act_mem[6'h12],
                              act_mem[6'h13], act_mem[6'h14], act_mem[6'h15]};
  assign ctrl_o.upd_rate = upd_n;
  assign ctrl_o.sweep_rate = {act_mem[6'h1A][3:0], act_mem[6'h1B], act_mem[6'h1C]};
  assign ctrl_o.power_down = act_mem[PWR_DOWN_OFS];
  assign ctrl_o.pll_setup = act_mem[PLL_SETUP_OFS];
  assign ctrl_o.op_mode = act_mem[OP_MODE_OFS];
  assign ctrl_o.out_port = act_mem[OUT_PORT_OFS];
  assign ctrl_o.amp_scale = {act_mem[6'h21][3:0], act_mem[6'h22]};
  assign ctrl_o.key_ramp = act_mem[KEY_RAMP_OFS];
  assign ctrl_o.aux_dac = {act_mem[6'h26][3:0], act_mem[6'h27]};
  assign mult_valid_o = (act_mem[PLL_SETUP_OFS][4:0] >= MULT_MIN) &&
                        (act_mem[PLL_SETUP_OFS][4:0] <= MULT_MAX);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i || !ce_i);

  logic [3:0] gap_cnt;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_cnt <= 4'hF;
    end else if (ce_i) begin
      gap_cnt <= par_wr ? 4'h0 : ((gap_cnt == 4'hF) ? gap_cnt : gap_cnt + 4'h1);
    end
  end

  sequence ud_started;
    int_tick && pulse_cnt == 4'h0 && !init_now;
  endsequence
  sequence ud_held;
    update_strobe_o [*8];
  endsequence

  upd_copy_a: assert property (upd_event |=> act_mem[TUNE_ONE_OFS] == $past(buf_mem[TUNE_ONE_OFS]))
    else $error("update did not copy buffer");
  no_ref_hold_a: assert property (!ref_present_o && !init_now |=> $stable(act_mem[TUNE_ONE_OFS]))
    else $error("active changed without reference");
  mrst_load_a: assert property (init_now |=> act_mem[PLL_SETUP_OFS] == PLL_SETUP_RST &&
                                buf_mem[KEY_RAMP_OFS] == KEY_RAMP_RST && ser_state == SER_INSTR)
    else $error("master reset did not load defaults");
  par_store_a: assert property (par_wr && !init_now && ddh_writable(pf.addr) |=>
                                buf_mem[$past(pf.addr)] == $past(pf.data))
    else $error("parallel write not stored");
  write_gap_a: assert property (par_wr |-> gap_cnt >= 4'(WRITE_GAP_CYC - 1))
    else $error("parallel writes taken too close");
  mult_range_a: assert property (mult_valid_o |-> ctrl_o.pll_setup[4:0] inside {[4:20]})
    else $error("multiplier flagged valid out of range");
  instr_end_a: assert property (rise && ser_state == SER_INSTR && bit_cnt == 3'h7 &&
                                !pf.addr[2] && !init_now |=> bit_cnt == 3'h0 &&
                                (ser_state == SER_DATA || span.len == 3'h0))
    else $error("instruction byte not closed after eight edges");
  resync_abort_a: assert property (pf.addr[2] |=> ser_state == SER_INSTR && bit_cnt == 3'h0)
    else $error("resync did not abort cycle");
  out_edge_a: assert property ($changed(out_bit) |-> $past(fall) || $past(rise))
    else $error("serial output changed off an edge");
  cs_float_a: assert property (cs_n |-> sdio_oe_b_o && serial_out_line_oe_b_o)
    else $error("serial pin driven with chip select high");
  ud_pulse_a: assert property (ud_started |=> ud_held)
    else $error("update pulse shorter than eight cycles");
endmodule
`default_nettype wire

// >>> hdl/ddh_pkg.sv
// Constants, carriers and helpers for the host configuration port.
// Assumes one system clock; all pin inputs are asynchronous to it.
package ddh_pkg;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int REG_BYTES = 40;
  localparam logic [5:0] PHASE_ONE_OFS = 6'h00;
  localparam logic [5:0] PHASE_TWO_OFS = 6'h02;
  localparam logic [5:0] TUNE_ONE_OFS = 6'h04;
  localparam logic [5:0] TUNE_TWO_OFS = 6'h0A;
  localparam logic [5:0] SWEEP_STEP_OFS = 6'h10;
  localparam logic [5:0] UPD_RATE_OFS = 6'h16;
  localparam logic [5:0] SWEEP_RATE_OFS = 6'h1A;
  localparam logic [5:0] PWR_DOWN_OFS = 6'h1D;
  localparam logic [5:0] PLL_SETUP_OFS = 6'h1E;
  localparam logic [5:0] OP_MODE_OFS = 6'h1F;
  localparam logic [5:0] OUT_PORT_OFS = 6'h20;
  localparam logic [5:0] AMP_SCALE_OFS = 6'h21;
  localparam logic [5:0] UNUSED_OFS = 6'h23;
  localparam logic [5:0] KEY_RAMP_OFS = 6'h25;
  localparam logic [5:0] AUX_DAC_OFS = 6'h26;
  localparam logic [5:0] LAST_OFS = 6'h27;
  localparam logic [7:0] UPD_RATE_LOW_RST = 8'h40;
  localparam logic [7:0] PWR_DOWN_RST = 8'h10;
  localparam logic [7:0] PLL_SETUP_RST = 8'h64;
  localparam logic [7:0] OP_MODE_RST = 8'h01;
  localparam logic [7:0] OUT_PORT_RST = 8'h20;
  localparam logic [7:0] KEY_RAMP_RST = 8'h80;
  localparam int INT_UPD_BIT = 0;
  localparam int ACC_PULSE_BIT = 7;
  localparam int SPLIT_OUT_BIT = 0;
  localparam int LSB_FIRST_BIT = 1;
  localparam int INSTR_RW_BIT = 7;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int WRITE_GAP_PS = 10500;
  localparam int WRITE_GAP_CYC = (WRITE_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] MRST_MIN_CYC = 4'hA;
  localparam logic [3:0] UD_PULSE_CYC = 4'h8;
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic mrst;
    logic reference_clock_in;
    logic ud;
    logic mode;
    logic wr_n;
    logic rd_n;
    logic [5:0] addr;
    logic [7:0] data;
  } ddh_pins_s;
  localparam ddh_pins_s PINS_IDLE = 20'h0C000;
  typedef struct packed {
    logic [5:0] base;
    logic [2:0] len;
  } ddh_span_s;
  typedef enum logic [1:0] {
    SER_INSTR = 2'b01,
    SER_DATA = 2'b10
  } ddh_ser_e;
  typedef struct packed {
    logic [13:0] phase_one;
    logic [13:0] phase_two;
    logic [47:0] tune_one;
    logic [47:0] tune_two;
    logic [47:0] sweep_step;
    logic [31:0] upd_rate;
    logic [19:0] sweep_rate;
    logic [7:0] power_down;
    logic [7:0] pll_setup;
    logic [7:0] op_mode;
    logic [7:0] out_port;
    logic [11:0] amp_scale;
    logic [7:0] key_ramp;
    logic [11:0] aux_dac;
  } ddh_ctrl_s;
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic ddh_span_s ddh_span(input logic [3:0] sa);
    case (sa)
      4'h0: ddh_span = '{PHASE_ONE_OFS, 3'h2};
      4'h1: ddh_span = '{PHASE_TWO_OFS, 3'h2};
      4'h2: ddh_span = '{TUNE_ONE_OFS, 3'h6};
      4'h3: ddh_span = '{TUNE_TWO_OFS, 3'h6};
      4'h4: ddh_span = '{SWEEP_STEP_OFS, 3'h6};
      4'h5: ddh_span = '{UPD_RATE_OFS, 3'h4};
      4'h6: ddh_span = '{SWEEP_RATE_OFS, 3'h3};
      4'h7: ddh_span = '{PWR_DOWN_OFS, 3'h4};
      4'h8: ddh_span = '{AMP_SCALE_OFS, 3'h2};
      4'h9: ddh_span = '{UNUSED_OFS, 3'h2};
      4'hA: ddh_span = '{KEY_RAMP_OFS, 3'h1};
      4'hB: ddh_span = '{AUX_DAC_OFS, 3'h2};
      default: ddh_span = '{6'h00, 3'h0};
    endcase
  endfunction
  function automatic logic [7:0] ddh_default(input logic [5:0] ofs);
    case (ofs)
      6'h19: ddh_default = UPD_RATE_LOW_RST;
      PWR_DOWN_OFS: ddh_default = PWR_DOWN_RST;
      PLL_SETUP_OFS: ddh_default = PLL_SETUP_RST;
      OP_MODE_OFS: ddh_default = OP_MODE_RST;
      OUT_PORT_OFS: ddh_default = OUT_PORT_RST;
      KEY_RAMP_OFS: ddh_default = KEY_RAMP_RST;
      default: ddh_default = 8'h00;
    endcase
  endfunction
  function automatic logic ddh_writable(input logic [5:0] ofs);
    ddh_writable = (ofs <= LAST_OFS) && (ofs != UNUSED_OFS) && (ofs != 6'h24);
  endfunction
endpackage

// >>> verification/ddh_host.sv
// Host controller model: parallel byte cycles and serial bit cycles.
// Assumes it shares clk_i with the port; pins change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ddh_host (
  input wire logic clk_i,
  input wire logic rx_i,
  input wire logic [7:0] pdata_i,
  input wire logic poe_b_i,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [5:0] addr_o,
  output logic [7:0] data_o
);
  // ------------------------------------------------------------------
  // Cycles
  // ------------------------------------------------------------------
  initial begin
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = 6'h00;
    data_o = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Strobe low 40 ns, high 60 ns: well above the write spacing
  task automatic pwr(input logic [5:0] a, input logic [7:0] d);
    addr_o <= a;
    data_o <= d;
    wr_n_o <= 1'b0;
    wt(4);
    wr_n_o <= 1'b1;
    wt(6);
  endtask
  task automatic prd(input logic [5:0] a, output logic [7:0] d, output logic oe_b);
    addr_o <= a;
    rd_n_o <= 1'b0;
    wt(10);
    d = pdata_i;
    oe_b = poe_b_i;
    rd_n_o <= 1'b1;
    wt(8);
  endtask
  task automatic cs(input logic v);
    rd_n_o <= v;
    addr_o[5:1] <= 5'h00;
    wt(8);
  endtask
  // Clock idles high between frames; 160 ns period
  task automatic sbit(input logic b, output logic q);
    wr_n_o <= 1'b0;
    addr_o[0] <= b;
    wt(8);
    q = rx_i;
    wr_n_o <= 1'b1;
    wt(8);
  endtask
  task automatic sbyte(input logic [7:0] b, input logic lsb, output logic [7:0] r);
    logic q;
    for (int i = 0; i < 8; i++) begin
      sbit(lsb ? b[i] : b[7-i], q);
      r[lsb ? i : 7-i] = q;
    end
  endtask
  task automatic rsync;
    addr_o[2] <= 1'b1;
    wt(8);
    addr_o[2] <= 1'b0;
    wt(8);
  endtask
endmodule
`default_nettype wire

// >>> verification/ddh_config_port_tb.sv
// Self-checking bench for the host configuration port.
// Assumes the host model drives strobes, address and data pins.
`timescale 1ns/1ps
`default_nettype none
module ddh_config_port_tb;
  import ddh_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk_i = 1'b0, rst_b_i = 1'b0, mode = 1'b1, mrst = 1'b0, ud = 1'b0;
  logic ref_on = 1'b0, refc = 1'b0, tgl = 1'b0, sd_seen = 1'b0, rx, wr_n, rd_n, oe;
  logic doe_b, so, so_oe_b, sd, sd_oe_b, uo, uo_oe_b, mv, rp;
  logic [5:0] addr;
  logic [7:0] din, dout, r;
  ddh_ctrl_s c;
  int miscompares = 0, cmp_count = 0, rc = 0;
  always #5 clk_i = ~clk_i;
  // Released lines show a changing pattern, never a held value
  assign rx = !sd_oe_b ? sd : (!so_oe_b ? so : tgl);
  always @(posedge clk_i) begin
    tgl <= ~tgl;
    rc <= rc + 1;
    if (ref_on && rc % 4 == 0) refc <= ~refc;
    if (sd_oe_b === 1'b0) sd_seen <= 1'b1;
  end
  ddh_config_port ddh_config_port_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .mode_sel_i(mode), .master_reset_i(mrst), .reference_clock_in_i(refc),
    .update_strobe_i(ud), .update_strobe_o(uo), .update_strobe_oe_b_o(uo_oe_b),
    .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .addr_i(addr), .data_i(din),
    .data_o(dout), .data_oe_b_o(doe_b), .serial_out_line_o(so),
    .serial_out_line_oe_b_o(so_oe_b), .sdio_o(sd), .sdio_oe_b_o(sd_oe_b), .ctrl_o(c),
    .mult_valid_o(mv), .ref_present_o(rp));
  ddh_host ddh_host_i (.clk_i(clk_i), .rx_i(rx), .pdata_i(dout), .poe_b_i(doe_b),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .addr_o(addr), .data_o(din));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic upd;
    ud <= 1'b1;
    wt(4);
    ud <= 1'b0;
    wt(10);
  endtask
  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    chk("ramp", 8'h80, c.key_ramp);
    chk("rate", 32'h40, c.upd_rate);
    chk("pll", 8'h64, c.pll_setup);
    chk("opm", 8'h01, c.op_mode);
    chk("outp", 8'h20, c.out_port);
    chk("pwr", 8'h10, c.power_down);
    chk("ud_oe", 1'b0, uo_oe_b);
    chk("sd_oe", 1'b1, sd_oe_b);
    chk("rp", 1'b0, rp);
    $display("t_reset done");
  endtask
  task automatic t_buffer;
    int n;
    ddh_host_i.pwr(6'h1F, 8'h00);
    ddh_host_i.pwr(6'h25, 8'h5A);
    wt(100);
    chk("ramp", 8'h80, c.key_ramp);
    ref_on <= 1'b1;
    n = 0;
    while (uo !== 1'b1 && n < 500) begin
      wt(1);
      n++;
    end
    if (n == 500) begin
      miscompares++;
      results();
    end
    n = 0;
    while (uo === 1'b1 && n < 20) begin
      wt(1);
      n++;
    end
    chk("ud_w", 48'd8, 48'(n));
    chk("rp", 1'b1, rp);
    wt(4);
    chk("ramp", 8'h5A, c.key_ramp);
    chk("ud_oe", 1'b1, uo_oe_b);
    ddh_host_i.pwr(6'h25, 8'h33);
    wt(100);
    chk("ramp", 8'h5A, c.key_ramp);
    upd();
    chk("ramp", 8'h33, c.key_ramp);
    $display("t_buffer done");
  endtask
  task automatic t_par;
    ddh_host_i.pwr(6'h23, 8'hFF);
    ddh_host_i.pwr(6'h00, 8'hFF);
    ddh_host_i.pwr(6'h01, 8'hFF);
    ddh_host_i.pwr(6'h1E, 8'h54);
    upd();
    chk("ph1", 14'h3FFF, c.phase_one);
    chk("mv", 1'b1, mv);
    ddh_host_i.prd(6'h25, r, oe);
    chk("rd25", 8'h33, r);
    chk("rd_oe", 1'b0, oe);
    ddh_host_i.prd(6'h23, r, oe);
    chk("rd23", 8'h00, r);
    ddh_host_i.pwr(6'h1E, 8'h55);
    upd();
    chk("mv", 1'b0, mv);
    $display("t_par done");
  endtask
  task automatic t_ser;
    logic q;
    mode <= 1'b0;
    wt(10);
    ddh_host_i.cs(1'b0);
    ddh_host_i.sbyte(8'h7A, 1'b0, r);
    ddh_host_i.sbyte(8'hC3, 1'b0, r);
    ddh_host_i.sbyte(8'h0B, 1'b0, r);
    ddh_host_i.sbyte(8'h01, 1'b0, r);
    ddh_host_i.sbyte(8'h23, 1'b0, r);
    upd();
    chk("ramp", 8'hC3, c.key_ramp);
    chk("aux", 12'h123, c.aux_dac);
    ddh_host_i.sbyte(8'h8A, 1'b0, r);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        ddh_host_i.cs(1'b1);
        chk("sd_oe", 1'b1, sd_oe_b);
        ddh_host_i.sbit(1'b1, q);
        ddh_host_i.cs(1'b0);
      end
      ddh_host_i.sbit(1'b0, q);
      r[7-i] = q;
    end
    chk("srd", 8'hC3, r);
    ddh_host_i.sbyte(8'h0A, 1'b0, r);
    ddh_host_i.sbit(1'b1, q);
    ddh_host_i.rsync();
    ddh_host_i.sbyte(8'h0A, 1'b0, r);
    ddh_host_i.sbyte(8'h77, 1'b0, r);
    upd();
    chk("ramp", 8'h77, c.key_ramp);
    $display("t_ser done");
  endtask
  task automatic t_lsb;
    ddh_host_i.sbyte(8'h07, 1'b0, r);
    ddh_host_i.sbyte(8'h10, 1'b0, r);
    ddh_host_i.sbyte(8'h64, 1'b0, r);
    ddh_host_i.sbyte(8'h00, 1'b0, r);
    ddh_host_i.sbyte(8'h03, 1'b0, r);
    upd();
    chk("outp", 8'h03, c.out_port);
    ddh_host_i.sbyte(8'h0A, 1'b1, r);
    ddh_host_i.sbyte(8'h96, 1'b1, r);
    upd();
    chk("ramp", 8'h96, c.key_ramp);
    sd_seen <= 1'b0;
    ddh_host_i.sbyte(8'h8A, 1'b1, r);
    ddh_host_i.sbyte(8'h00, 1'b1, r);
    chk("split", 8'h96, r);
    chk("sd_dr", 1'b0, sd_seen);
    $display("t_lsb done");
  endtask
  task automatic t_mrst;
    mrst <= 1'b1;
    wt(20);
    mrst <= 1'b0;
    wt(10);
    chk("ramp", 8'h80, c.key_ramp);
    chk("outp", 8'h20, c.out_port);
    chk("ud_oe", 1'b0, uo_oe_b);
    $display("t_mrst done");
  endtask
  initial begin
    wt(3);
    rst_b_i <= 1'b1;
    wt(2);
    t_reset();
    t_buffer();
    t_par();
    t_ser();
    t_lsb();
    t_mrst();
    results();
  end
endmodule
`default_nettype wire
